/* File: rtl/mios_pkg.sv */
// Shared constants and types of the memory I/O register stage.
// Assumes one 10 MHz system clock and a 32-bit memory data bus.
package mios_pkg;

  localparam int MIOS_CLK_NS = 100;
  // Least strobe time of one memory access
  localparam int MIOS_ACC_NS = 200;
  localparam int MIOS_ACC_CYC = (MIOS_ACC_NS + MIOS_CLK_NS - 1) / MIOS_CLK_NS;

  localparam int MIOS_DW = 32;
  localparam int MIOS_AW = 32;
  localparam int MIOS_BW = 4;
  localparam int MIOS_CNT_W = 4;
  localparam int MIOS_FIFO_DEPTH = 8;

  // Big-endian byte lanes: memory bit 0 is the top bit of the vectors
  localparam int MIOS_LANE8_TOP = 24;
  localparam int MIOS_LANE16_TOP = 16;

  localparam logic MIOS_STROBE_OFF = 1'b1;
  localparam logic [MIOS_BW-1:0] MIOS_BEN_OFF = 4'hf;
  localparam logic [MIOS_DW-1:0] MIOS_DQ_RST = 32'h0000_0000;

  localparam logic [1:0] MIOS_LAST_W8 = 2'h3;
  localparam logic [1:0] MIOS_LAST_W16 = 2'h1;
  localparam logic [1:0] MIOS_LAST_W32 = 2'h0;
  localparam logic [MIOS_AW-1:0] MIOS_STEP_W8 = 32'h0000_0001;
  localparam logic [MIOS_AW-1:0] MIOS_STEP_W16 = 32'h0000_0002;
  localparam logic [MIOS_AW-1:0] MIOS_STEP_W32 = 32'h0000_0004;

  typedef enum logic [1:0] {
    MIOS_W8 = 2'b00,
    MIOS_W16 = 2'b01,
    MIOS_W32 = 2'b10
  } mios_width_t;

  typedef enum logic [1:0] {
    MIOS_IDLE = 2'b00,
    MIOS_GAP = 2'b01,
    MIOS_ACC = 2'b10
  } mios_state_t;

endpackage

/* File: rtl/mios_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share the one clock and reset.
`timescale 1ns/1ps
module mios_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } mios_fifo_st_t;

  mios_fifo_st_t r;
  mios_fifo_st_t next_r;
  logic do_push;
  logic do_pop;

  assign in_ready = (r.count != CNT_FULL);
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    next_r = r;
    if (do_push) begin
      next_r.mem[r.wptr] = in_data;
      next_r.wptr = (r.wptr == PTR_LAST) ? '0 : PW'(r.wptr + 1'b1);
    end
    if (do_pop) begin
      next_r.rptr = (r.rptr == PTR_LAST) ? '0 : PW'(r.rptr + 1'b1);
    end
    if (do_push && !do_pop) begin
      next_r.count = CW'(r.count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_r.count = CW'(r.count - 1'b1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

/* File: rtl/mios_io_stage.sv */
// I/O register stage between the memory controller core and the banks.
// Assumes the core keeps its request steady while req_valid is high and
// that memories answer within the strobe time set in the package.
//
// Behaviour
// - Every memory output leaves a rising-edge register.
// - Falling-edge option re-registers every memory output.
// - Falling-edge option samples read data on falling edge.
// - Width matching adds a rising input register.
// - No width matching: that extra register is absent.
// - Narrow matched bank: several accesses, address advances.
// - Matched write: word lanes, most significant first.
// - Matched read: fill lanes, answer when complete.
// - Narrow banks sit on top data bits.
`timescale 1ns/1ps
module mios_io_stage
  import mios_pkg::*;
#(
  parameter bit falling_edge_io_stage_enable = 1'b0,
  parameter bit width_matching_enable = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_rnw,
  input wire logic [MIOS_AW-1:0] req_addr,
  input wire logic [MIOS_DW-1:0] req_wdata,
  input wire logic [MIOS_BW-1:0] req_be,
  input wire mios_width_t req_width,
  output logic wr_done,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [MIOS_DW-1:0] rd_data,
  output logic [MIOS_AW-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic [MIOS_BW-1:0] mem_ben_n,
  input wire logic [MIOS_DW-1:0] mem_dq_in,
  output logic [MIOS_DW-1:0] mem_dq_out,
  output logic mem_dq_oe_n
);

  localparam bit NEG = falling_edge_io_stage_enable;
  localparam bit WM = width_matching_enable;
  localparam int IN_LAT = WM ? 2 : 1;
  localparam int RD_HOLD = MIOS_ACC_CYC + IN_LAT;
  localparam int WR_HOLD = MIOS_ACC_CYC;

  typedef struct packed {
    mios_state_t st;
    logic [MIOS_CNT_W-1:0] cnt;
    logic [1:0] beat;
    logic [1:0] last;
    logic rnw;
    mios_width_t width;
    logic [MIOS_AW-1:0] addr;
    logic [MIOS_DW-1:0] wdata;
    logic [MIOS_BW-1:0] be;
    logic [MIOS_DW-1:0] asm_w;
    logic [MIOS_AW-1:0] o_addr;
    logic o_ce_n;
    logic o_we_n;
    logic o_oe_n;
    logic [MIOS_BW-1:0] o_ben_n;
    logic [MIOS_DW-1:0] o_dq;
    logic o_dq_oe_n;
    logic [MIOS_DW-1:0] in_r;
    logic [MIOS_DW-1:0] wm_r;
    logic wr_done;
    logic push;
  } mios_core_t;

  typedef struct packed {
    logic [MIOS_AW-1:0] o_addr;
    logic o_ce_n;
    logic o_we_n;
    logic o_oe_n;
    logic [MIOS_BW-1:0] o_ben_n;
    logic [MIOS_DW-1:0] o_dq;
    logic o_dq_oe_n;
    logic [MIOS_DW-1:0] in_f;
  } mios_fall_t;

  localparam mios_core_t CORE_RST = '{
    st: MIOS_IDLE, width: MIOS_W32, o_ce_n: MIOS_STROBE_OFF,
    o_we_n: MIOS_STROBE_OFF, o_oe_n: MIOS_STROBE_OFF,
    o_ben_n: MIOS_BEN_OFF, o_dq: MIOS_DQ_RST,
    o_dq_oe_n: MIOS_STROBE_OFF, default: '0};
  localparam mios_fall_t FALL_RST = '{
    o_ce_n: MIOS_STROBE_OFF, o_we_n: MIOS_STROBE_OFF,
    o_oe_n: MIOS_STROBE_OFF, o_ben_n: MIOS_BEN_OFF,
    o_dq: MIOS_DQ_RST, o_dq_oe_n: MIOS_STROBE_OFF, default: '0};

  mios_core_t r;
  mios_core_t next_r;
  mios_fall_t f;
  mios_fall_t next_f;
  logic fifo_in_ready;
  logic [MIOS_DW-1:0] in_src;
  logic [MIOS_DW-1:0] mux_src;
  logic [MIOS_CNT_W-1:0] hold_last;

  // Write lane of beat b moved onto the top memory bits
  function automatic logic [MIOS_DW-1:0] lane_out(
    input logic [MIOS_DW-1:0] w, input mios_width_t wd,
    input logic [1:0] b);
    logic [MIOS_DW-1:0] s;
    s = '0;
    case (wd)
      MIOS_W8: begin
        s = w << {b, 3'b000};
        s = {s[MIOS_DW-1:MIOS_LANE8_TOP], 24'h00_0000};
      end
      MIOS_W16: begin
        s = w << {b[0], 4'h0};
        s = {s[MIOS_DW-1:MIOS_LANE16_TOP], 16'h0000};
      end
      default: s = w;
    endcase
    return s;
  endfunction

  // Read lane of beat b placed into its slot of the assembly word
  function automatic logic [MIOS_DW-1:0] lane_in(
    input logic [MIOS_DW-1:0] acc, input logic [MIOS_DW-1:0] d,
    input mios_width_t wd, input logic [1:0] b);
    logic [MIOS_DW-1:0] s;
    s = d;
    case (wd)
      MIOS_W8: s = acc | ({d[MIOS_DW-1:MIOS_LANE8_TOP], 24'h00_0000}
        >> {b, 3'b000});
      MIOS_W16: s = acc | ({d[MIOS_DW-1:MIOS_LANE16_TOP], 16'h0000}
        >> {b[0], 4'h0});
      default: s = d;
    endcase
    return s;
  endfunction

  function automatic logic [MIOS_BW-1:0] lane_ben(
    input logic [MIOS_BW-1:0] be, input mios_width_t wd,
    input logic [1:0] b);
    logic [MIOS_BW-1:0] s;
    s = ~be;
    case (wd)
      MIOS_W8: begin
        s = be << b;
        s = {~s[3], 3'b111};
      end
      MIOS_W16: begin
        s = be << {b[0], 1'b0};
        s = {~s[3:2], 2'b11};
      end
      default: s = ~be;
    endcase
    return s;
  endfunction

  // Without the option the falling input register is constant and trims away
  assign in_src = NEG ? f.in_f : r.in_r;
  // Width matching reads the extra register, otherwise the I/O one
  assign mux_src = WM ? r.wm_r : in_src;
  assign hold_last = r.rnw ? MIOS_CNT_W'(RD_HOLD - 1) :
    MIOS_CNT_W'(WR_HOLD - 1);

  always_comb begin
    next_r = r;
    next_r.wr_done = 1'b0;
    next_r.push = 1'b0;
    next_r.in_r = NEG ? '0 : mem_dq_in;
    next_r.wm_r = WM ? in_src : '0;
    unique case (r.st)
      MIOS_IDLE: begin
        if (req_valid && req_ready) begin
          next_r.st = MIOS_GAP;
          next_r.rnw = req_rnw;
          next_r.width = req_width;
          next_r.addr = req_addr;
          next_r.wdata = req_wdata;
          next_r.be = req_be;
          next_r.asm_w = '0;
          next_r.beat = '0;
          next_r.last = MIOS_LAST_W32;
          if (WM && req_width == MIOS_W8) begin
            next_r.last = MIOS_LAST_W8;
          end else if (WM && req_width == MIOS_W16) begin
            next_r.last = MIOS_LAST_W16;
          end
        end
      end
      MIOS_GAP: begin
        // Strobes rise for one cycle between beats as recovery time
        next_r.st = MIOS_ACC;
        next_r.cnt = '0;
        next_r.o_addr = r.addr;
        next_r.o_ce_n = 1'b0;
        next_r.o_we_n = r.rnw;
        next_r.o_oe_n = !r.rnw;
        next_r.o_dq_oe_n = r.rnw;
        next_r.o_dq = lane_out(r.wdata, r.width, r.beat);
        next_r.o_ben_n = lane_ben(r.be, r.width, r.beat);
      end
      MIOS_ACC: begin
        next_r.cnt = MIOS_CNT_W'(r.cnt + 1'b1);
        if (r.cnt == hold_last) begin
          if (r.rnw) begin
            next_r.asm_w = lane_in(r.asm_w, mux_src, r.width, r.beat);
          end
          next_r.o_ce_n = MIOS_STROBE_OFF;
          next_r.o_we_n = MIOS_STROBE_OFF;
          next_r.o_oe_n = MIOS_STROBE_OFF;
          next_r.o_dq_oe_n = MIOS_STROBE_OFF;
          next_r.o_ben_n = MIOS_BEN_OFF;
          if (r.beat == r.last) begin
            next_r.st = MIOS_IDLE;
            next_r.push = r.rnw;
            next_r.wr_done = !r.rnw;
          end else begin
            next_r.st = MIOS_GAP;
            next_r.beat = 2'(r.beat + 1'b1);
            if (r.width == MIOS_W8) begin
              next_r.addr = MIOS_AW'(r.addr + MIOS_STEP_W8);
            end else if (r.width == MIOS_W16) begin
              next_r.addr = MIOS_AW'(r.addr + MIOS_STEP_W16);
            end else begin
              next_r.addr = MIOS_AW'(r.addr + MIOS_STEP_W32);
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    next_f.o_addr = r.o_addr;
    next_f.o_ce_n = r.o_ce_n;
    next_f.o_we_n = r.o_we_n;
    next_f.o_oe_n = r.o_oe_n;
    next_f.o_ben_n = r.o_ben_n;
    next_f.o_dq = r.o_dq;
    next_f.o_dq_oe_n = r.o_dq_oe_n;
    next_f.in_f = NEG ? mem_dq_in : '0;
  end

  // Half-cycle stage buys setup and hold only at slow clocks
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      f <= FALL_RST;
    end else begin
      f <= next_f;
    end
  end

  assign mem_addr = NEG ? f.o_addr : r.o_addr;
  assign mem_ce_n = NEG ? f.o_ce_n : r.o_ce_n;
  assign mem_we_n = NEG ? f.o_we_n : r.o_we_n;
  assign mem_oe_n = NEG ? f.o_oe_n : r.o_oe_n;
  assign mem_ben_n = NEG ? f.o_ben_n : r.o_ben_n;
  assign mem_dq_out = NEG ? f.o_dq : r.o_dq;
  assign mem_dq_oe_n = NEG ? f.o_dq_oe_n : r.o_dq_oe_n;

  // A push pending this cycle may take the last free slot
  assign req_ready = (r.st == MIOS_IDLE) && !r.push && fifo_in_ready;
  assign wr_done = r.wr_done;

  mios_fifo #(
    .WIDTH(MIOS_DW),
    .DEPTH(MIOS_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(r.push),
    .in_ready(fifo_in_ready),
    .in_data(r.asm_w),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  property p_strobe_reg;
    @(posedge clk_sys) disable iff (rst)
    (r.st == MIOS_ACC) == !r.o_ce_n;
  endproperty
  a_strobe_reg: assert property (p_strobe_reg)
    else $error("chip enable not tied to access state");

  property p_fall_copy;
    @(posedge clk_sys) disable iff (rst)
    NEG |-> (mem_ce_n == r.o_ce_n && mem_addr == r.o_addr
      && mem_dq_out == r.o_dq);
  endproperty
  a_fall_copy: assert property (p_fall_copy)
    else $error("falling stage does not follow rising stage");

  property p_fall_in;
    @(negedge clk_sys) disable iff (rst)
    NEG |=> f.in_f == $past(mem_dq_in);
  endproperty
  a_fall_in: assert property (p_fall_in)
    else $error("read data not sampled on falling edge");

  property p_wm_reg;
    @(posedge clk_sys) disable iff (rst)
    WM |=> r.wm_r == $past(in_src);
  endproperty
  a_wm_reg: assert property (p_wm_reg)
    else $error("width matching register missed a cycle");

  property p_no_wm_reg;
    @(posedge clk_sys) disable iff (rst)
    !WM |-> r.wm_r == '0;
  endproperty
  a_no_wm_reg: assert property (p_no_wm_reg)
    else $error("extra input register present without matching");

  property p_addr_step;
    @(posedge clk_sys) disable iff (rst)
    (r.st == MIOS_GAP && r.beat != 2'h0 && r.width == MIOS_W8)
      |=> r.o_addr == $past(r.addr) && !r.o_ce_n
      ##1 $stable(r.o_addr);
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("narrow access address not held or advanced");

  property p_wr_lane;
    @(posedge clk_sys) disable iff (rst)
    (r.st == MIOS_ACC && !r.rnw && r.width == MIOS_W8 && WM)
      |-> r.o_dq[31:24] == 8'(r.wdata >> (6'd24 - {r.beat, 3'b000}))
      && r.o_dq[23:0] == 24'h00_0000;
  endproperty
  a_wr_lane: assert property (p_wr_lane)
    else $error("write byte lane out of order");

  property p_rd_done;
    @(posedge clk_sys) disable iff (rst)
    r.push |-> $past(r.beat) == $past(r.last)
      && $past(r.st) == MIOS_ACC && $past(r.rnw);
  endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("read answered before all lanes filled");

  property p_idle_off;
    @(posedge clk_sys) disable iff (rst)
    (r.st == MIOS_IDLE) |-> r.o_ce_n && r.o_we_n && r.o_oe_n
      && r.o_dq_oe_n && r.o_ben_n == MIOS_BEN_OFF;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("memory strobe active while idle");

endmodule

/* File: testbench/mios_mem_model.sv */
// Behavioural memory bank on the far side of the I/O register stage.
// Assumes the bench feeds it the width of the bank being accessed.
`timescale 1ns/1ps
module mios_mem_model
  import mios_pkg::*;
(
  input wire logic clk_sys,
  input wire mios_width_t width,
  input wire logic [MIOS_AW-1:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic [MIOS_BW-1:0] mem_ben_n,
  input wire logic [MIOS_DW-1:0] mem_dq_out,
  input wire logic mem_dq_oe_n,
  output logic [MIOS_DW-1:0] mem_dq_in
);
  logic [7:0] mem_q [0:15];
  logic [MIOS_DW-1:0] last_q = '0;
  logic [3:0] a;
  logic drive;
  int n;
  assign a = mem_addr[3:0];
  assign drive = !mem_ce_n && !mem_oe_n;
  // Cleared so that reads of untouched neighbour bytes carry no unknowns
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 8'h00;
    end
  end
  always_comb n = (width == MIOS_W8) ? 1 : (width == MIOS_W16) ? 2 : 4;
  // Narrow banks sit on the top lanes, address bytes big-endian
  always @(posedge clk_sys) begin
    if (!mem_ce_n && !mem_we_n && !mem_dq_oe_n) begin
      for (int i = 0; i < n; i++) begin
        if (!mem_ben_n[3-i]) begin
          mem_q[a+4'(i)] <= mem_dq_out[31-8*i -: 8];
        end
      end
    end
    if (drive) begin
      last_q <= mem_dq_in;
    end
  end
  // Released bus shows the inverse of its last value, never a stale copy
  assign mem_dq_in = drive ? {mem_q[a], mem_q[a+4'h1], mem_q[a+4'h2],
                              mem_q[a+4'h3]} : ~last_q;
endmodule

/* File: testbench/mios_io_stage_bench.sv */
// Self-checking bench for the memory I/O register stage.
// Assumes width matching on; a second instance runs the falling-edge stage.
`timescale 1ns/1ps
`define CHECK(nm, e, g) chk(nm, 32'(e), 32'(g))
module mios_io_stage_bench
  import mios_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_rnw = 1'b0;
  logic [MIOS_AW-1:0] req_addr = 32'h0000_0000;
  logic [MIOS_DW-1:0] req_wdata = 32'h0000_0000;
  logic [MIOS_BW-1:0] req_be = 4'hf;
  mios_width_t req_width = MIOS_W32;
  logic rd_ready = 1'b0;
  logic req_ready, wr_done, rd_valid, mem_ce_n, mem_we_n, mem_oe_n;
  logic mem_dq_oe_n;
  logic [MIOS_DW-1:0] rd_data, mem_dq_in, mem_dq_out;
  logic [MIOS_AW-1:0] mem_addr;
  logic [MIOS_BW-1:0] mem_ben_n;
  logic req_ready_f, wr_done_f, rd_valid_f, ce_n_f, we_n_f, oe_n_f;
  logic dq_oe_n_f;
  logic [MIOS_DW-1:0] rd_data_f, dq_in_f, dq_out_f;
  logic [MIOS_AW-1:0] addr_f;
  logic [MIOS_BW-1:0] ben_n_f;
  int err_count = 0;
  int checked = 0;

  always #50 clk_sys = ~clk_sys;

  // Asynchronous-only memory, so the falling-edge option stays off
  mios_io_stage #(.falling_edge_io_stage_enable(1'b0),
    .width_matching_enable(1'b1)) uut (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_rnw(req_rnw),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .req_width(req_width), .wr_done(wr_done), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
    .mem_ben_n(mem_ben_n), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n));

  mios_mem_model mem (.clk_sys(clk_sys), .width(req_width),
    .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
    .mem_oe_n(mem_oe_n), .mem_ben_n(mem_ben_n), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in));

  // Mixed-system variant with the falling-edge stage on, run in lockstep
  mios_io_stage #(.falling_edge_io_stage_enable(1'b1),
    .width_matching_enable(1'b1)) uut_f (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready_f), .req_rnw(req_rnw),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .req_width(req_width), .wr_done(wr_done_f), .rd_valid(rd_valid_f),
    .rd_ready(rd_ready), .rd_data(rd_data_f), .mem_addr(addr_f),
    .mem_ce_n(ce_n_f), .mem_we_n(we_n_f), .mem_oe_n(oe_n_f),
    .mem_ben_n(ben_n_f), .mem_dq_in(dq_in_f), .mem_dq_out(dq_out_f),
    .mem_dq_oe_n(dq_oe_n_f));

  mios_mem_model mem_f (.clk_sys(clk_sys), .width(req_width),
    .mem_addr(addr_f), .mem_ce_n(ce_n_f), .mem_we_n(we_n_f),
    .mem_oe_n(oe_n_f), .mem_ben_n(ben_n_f), .mem_dq_out(dq_out_f),
    .mem_dq_oe_n(dq_oe_n_f), .mem_dq_in(dq_in_f));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (e !== g) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic timeout(input string nm);
    err_count++;
    $display("[FAIL] %s expected handshake seen none", nm);
    end_of_test();
  endtask

  // One request; lat of 0 skips the answer wait, pop takes the read word
  task automatic xfer(input logic rnw, input logic [31:0] ad,
      input logic [31:0] wd, input mios_width_t w, input int lat,
      input logic [31:0] exp_rd, input logic pop);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_rnw = rnw;
    req_addr = ad;
    req_wdata = wd;
    req_width = w;
    n = 0;
    #1;
    while (req_ready !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 100) timeout("req_ready");
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 1;
    if (lat > 0) begin
      while ((rnw ? rd_valid : wr_done) !== 1'b1) begin
        @(negedge clk_sys);
        n++;
        if (n > 100) timeout("answer");
      end
      `CHECK("latency", lat, n);
      `CHECK("fall answer", 1'b1, rnw ? rd_valid_f : wr_done_f);
    end
    if (pop) begin
      `CHECK("rd_data", exp_rd, rd_data);
      `CHECK("fall rd_data", exp_rd, rd_data_f);
      rd_ready = 1'b1;
      @(negedge clk_sys);
      rd_ready = 1'b0;
    end
  endtask

  task automatic t_reset();
    `CHECK("ce_n", 1'b1, mem_ce_n);
    `CHECK("we_n", 1'b1, mem_we_n);
    `CHECK("oe_n", 1'b1, mem_oe_n);
    `CHECK("dq_oe_n", 1'b1, mem_dq_oe_n);
    `CHECK("ben_n", 4'hf, mem_ben_n);
    `CHECK("fall ce_n", 1'b1, ce_n_f);
    `CHECK("rd_valid", 1'b0, rd_valid);
    $display("test reset done");
  endtask

  // Full-width word: one beat, rising-edge capture then the matching stage
  task automatic t_word();
    xfer(1'b0, 32'h0000_0000, 32'h1234_5678, MIOS_W32, 4, 0, 0);
    `CHECK("mem byte0", 8'h12, mem.mem_q[0]);
    `CHECK("mem byte3", 8'h78, mem.mem_q[3]);
    xfer(1'b1, 32'h0000_0000, 0, MIOS_W32, 7, 32'h1234_5678, 1);
    $display("test word done");
  endtask

  // Byte bank: four beats, top byte first, address stepping by one
  task automatic t_byte();
    xfer(1'b0, 32'h0000_0008, 32'h9abc_defa, MIOS_W8, 13, 0, 0);
    `CHECK("byte at 8", 8'h9a, mem.mem_q[8]);
    `CHECK("byte at 9", 8'hbc, mem.mem_q[9]);
    `CHECK("byte at a", 8'hde, mem.mem_q[10]);
    `CHECK("byte at b", 8'hfa, mem.mem_q[11]);
    `CHECK("fall byte at b", 8'hfa, mem_f.mem_q[11]);
    xfer(1'b1, 32'h0000_0008, 0, MIOS_W8, 22, 32'h9abc_defa, 1);
    $display("test byte done");
  endtask

  // Halfword bank: two beats on the top sixteen data bits
  task automatic t_half();
    xfer(1'b0, 32'h0000_0004, 32'ha1b2_c3d4, MIOS_W16, 7, 0, 0);
    `CHECK("half at 4", 8'ha1, mem.mem_q[4]);
    `CHECK("half at 7", 8'hd4, mem.mem_q[7]);
    xfer(1'b1, 32'h0000_0004, 0, MIOS_W16, 12, 32'ha1b2_c3d4, 1);
    $display("test half done");
  endtask

  // Reads pile up unread until the buffer refuses, then drain in order
  task automatic t_fifo();
    for (int i = 0; i < MIOS_FIFO_DEPTH; i++) begin
      xfer(1'b1, 32'h0000_0000, 0, MIOS_W32, (i == 0) ? 7 : 0, 0, 0);
    end
    repeat (8) @(negedge clk_sys);
    `CHECK("req_ready full", 1'b0, req_ready);
    `CHECK("fall req_ready full", 1'b0, req_ready_f);
    for (int i = 0; i < MIOS_FIFO_DEPTH; i++) begin
      `CHECK("rd_valid", 1'b1, rd_valid);
      `CHECK("drain", 32'h1234_5678, rd_data);
      `CHECK("fall drain", 32'h1234_5678, rd_data_f);
      rd_ready = 1'b1;
      @(negedge clk_sys);
      rd_ready = 1'b0;
      @(negedge clk_sys);
    end
    `CHECK("rd_valid empty", 1'b0, rd_valid);
    $display("test fifo done");
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    t_reset();
    rst = 1'b0;
    @(negedge clk_sys);
    t_word();
    t_byte();
    t_half();
    t_fifo();
    end_of_test();
  end
endmodule
